// file: core/dsp_unit.sv
// Fixed-point SIMD datapath with accumulators and extension control state
`timescale 1ns/1ps
module dsp_unit (
	input wire logic CLOCK,
	input wire logic RST,
	input wire dsp_unit_pkg::op_request_t REQ,
	input wire logic ENABLE,
	input wire logic BIG_ENDIAN,
	output dsp_unit_pkg::op_response_t RESP,
	output logic [31:0] CONTROL_STATE
);

	// ********************************
	// Helpers
	// ********************************
	function automatic int fmt_width(input dsp_unit_pkg::lane_fmt_t f);
		case (f)
			dsp_unit_pkg::FMT_WORD: return dsp_unit_pkg::WORD_W;
			dsp_unit_pkg::FMT_PAIRED_HALF: return dsp_unit_pkg::HALF_W;
			dsp_unit_pkg::FMT_QUAD_BYTE: return dsp_unit_pkg::BYTE_W;
			default: return dsp_unit_pkg::WORD_W;
		endcase
	endfunction

	// Every lane is widened on its own, so no carry or clamp leaks sideways
	function automatic logic [32:0] lane_addsub(input logic [31:0] a, input logic [31:0] b, input int w,
		input logic sub, input logic uns, input logic sat);
		logic [33:0] mask, smax, smin, ea, eb, sum, r;
		logic [31:0] res;
		logic ovf, under, out;
		mask = (34'h1 << w) - 34'h1;
		smax = mask >> 1;
		smin = ~smax;
		res = '0;
		ovf = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (i * w < 32) begin
				ea = ({2'h0, a} >> (i * w)) & mask;
				eb = ({2'h0, b} >> (i * w)) & mask;
				if (!uns && ea[w-1]) ea = ea | ~mask;
				if (!uns && eb[w-1]) eb = eb | ~mask;
				sum = sub ? ea - eb : ea + eb;
				if (uns) begin
					under = sum[33];
					out = (sum & ~mask) != 34'h0;
				end else begin
					under = $signed(sum) < $signed(smin);
					out = under || ($signed(sum) > $signed(smax));
				end
				r = sum & mask;
				if (sat && out) begin
					if (uns) r = under ? 34'h0 : mask;
					else r = under ? (smin & mask) : smax;
				end
				ovf = ovf | out;
				res = res | 32'(r << (i * w));
			end
		end
		return {ovf, res};
	endfunction

	// Signed fractional product in Q(2w-1); operands are never read as unsigned
	function automatic logic [64:0] frac_mul(input logic [31:0] a, input logic [31:0] b, input int w,
		input logic rnd);
		logic [63:0] m, minv, ea, eb, p;
		logic ovf;
		m = (64'h1 << w) - 64'h1;
		minv = 64'h1 << (w - 1);
		ea = {32'h0, a} & m;
		eb = {32'h0, b} & m;
		ovf = (ea == minv) && (eb == minv);
		if (ea[w-1]) ea = ea | ~m;
		if (eb[w-1]) eb = eb | ~m;
		p = (ea * eb) << 1;
		if (ovf) p = (64'h1 << (2 * w - 1)) - 64'h1;
		else if (rnd) p = p + (64'h1 << (w - 1));
		return {ovf, p};
	endfunction

	// Upper half of each input lane, optionally rounded with clamp
	function automatic logic [32:0] reduce_lanes(input logic [31:0] a, input logic [31:0] b, input int wi,
		input logic rnd);
		logic [63:0] src, lane, t, mi, mo;
		logic [31:0] r;
		logic ovf;
		int wo;
		wo = wi / 2;
		src = {a, b};
		mi = (64'h1 << wi) - 64'h1;
		mo = (64'h1 << wo) - 64'h1;
		r = '0;
		ovf = 1'b0;
		for (int k = 0; k < 4; k++) begin
			if (k * wi < 64) begin
				lane = (src >> (k * wi)) & mi;
				t = lane;
				if (rnd) t = (lane + (64'h1 << (wo - 1))) & mi;
				if (rnd && !lane[wi-1] && t[wi-1]) begin
					ovf = 1'b1;
					t = mi >> 1;
				end
				r = r | 32'(((t >> wo) & mo) << (k * wo));
			end
		end
		return {ovf, r};
	endfunction

	function automatic logic [31:0] arrange_lanes(input logic [31:0] v, input int w, input logic big);
		logic [31:0] r;
		int n;
		n = 32 / w;
		r = v;
		if (big) begin
			r = '0;
			for (int k = 0; k < 4; k++) begin
				if (k < n) r = r | 32'(((64'(v) >> (k * w)) & ((64'h1 << w) - 64'h1)) << ((n - 1 - k) * w));
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] ctrl_word(input dsp_unit_pkg::ctrl_fields_t c);
		logic [31:0] r;
		r = '0;
		r[dsp_unit_pkg::POS_LSB +: dsp_unit_pkg::POS_W] = c.pos;
		r[dsp_unit_pkg::SCOUNT_LSB +: dsp_unit_pkg::SCOUNT_W] = c.scount;
		r[dsp_unit_pkg::CARRY_BIT] = c.carry;
		r[dsp_unit_pkg::EXTRACT_FAIL_BIT] = c.extract_fail_flag;
		r[dsp_unit_pkg::OUFLAG_LSB +: dsp_unit_pkg::OUFLAG_W] = c.ouflag;
		r[dsp_unit_pkg::CCOND_LSB +: dsp_unit_pkg::CCOND_W] = c.ccond;
		return r;
	endfunction

	// ********************************
	// State
	// ********************************
	dsp_unit_pkg::unit_state_t q, d;
	logic [4:0] size_eff;
	logic [5:0] pos_after_dec;
	logic add_carry;

	assign size_eff = REQ.var_size ? REQ.opa[4:0] : REQ.size;
	assign pos_after_dec = q.ctrl.pos - {1'b0, size_eff} - 6'h01;
	assign add_carry = 1'({1'b0, REQ.opa} + {1'b0, REQ.opb} >> 32);

	always_comb begin
		logic [32:0] ar;
		logic [64:0] mp;
		logic [63:0] accv, lmask, ins_mask;
		logic [64:0] acc_sum;
		logic [32:0] csum;
		logic [31:0] mres;
		logic fail;
		int wi, wo;
		ar = '0;
		mp = '0;
		lmask = '0;
		ins_mask = '0;
		acc_sum = '0;
		csum = '0;
		mres = '0;
		fail = 1'b0;
		wi = fmt_width(REQ.fmt_in);
		wo = fmt_width(REQ.fmt_out);
		accv = {q.acc_hi[REQ.acc_sel], q.acc_lo[REQ.acc_sel]};
		d = q;
		d.resp.valid = 1'b0;
		d.resp.write_gpr = 1'b0;
		d.resp.exc = 1'b0;
		d.resp.exc_code = '0;
		if (REQ.valid && !ENABLE) begin
			// Nothing else changes; the core takes the exception instead
			d.resp.valid = 1'b1;
			d.resp.exc = 1'b1;
			d.resp.exc_code = dsp_unit_pkg::STATE_DISABLED_CODE;
		end else if (REQ.valid) begin
			d.resp.valid = 1'b1;
			d.resp.write_gpr = !(REQ.op inside {dsp_unit_pkg::OP_MUL_ACC, dsp_unit_pkg::OP_ACC_SHIFT,
				dsp_unit_pkg::OP_ACC_WRITE, dsp_unit_pkg::OP_CTRL_WRITE});
			d.resp.data = '0;
			unique case (REQ.op)
				dsp_unit_pkg::OP_ADD, dsp_unit_pkg::OP_SUB: begin
					ar = lane_addsub(REQ.opa, REQ.opb, wi, REQ.op == dsp_unit_pkg::OP_SUB, REQ.uns, REQ.sat);
					d.resp.data = ar[31:0];
					if (ar[32]) d.ctrl.ouflag[dsp_unit_pkg::OUF_ADD_BIT] = 1'b1;
				end
				dsp_unit_pkg::OP_FRAC_MUL: begin
					lmask = (64'h1 << wi) - 64'h1;
					for (int i = 0; i < 4; i++) begin
						if (i * wi < 32) begin
							mp = frac_mul(REQ.opa >> (i * wi), REQ.opb >> (i * wi), wi, REQ.round);
							mres = mres | 32'(((mp[63:0] >> wi) & lmask) << (i * wi));
							if (mp[64]) d.ctrl.ouflag[dsp_unit_pkg::OUF_MUL_BIT] = 1'b1;
						end
					end
					d.resp.data = mres;
				end
				dsp_unit_pkg::OP_FRAC_MUL_WIDE, dsp_unit_pkg::OP_MUL_ACC: begin
					mp = frac_mul(REQ.left ? {16'h0, REQ.opa[31:16]} : {16'h0, REQ.opa[15:0]},
						REQ.left ? {16'h0, REQ.opb[31:16]} : {16'h0, REQ.opb[15:0]}, dsp_unit_pkg::HALF_W, 1'b0);
					if (mp[64]) d.ctrl.ouflag[dsp_unit_pkg::OUF_MUL_BIT] = 1'b1;
					d.resp.data = mp[31:0];
					if (REQ.op == dsp_unit_pkg::OP_MUL_ACC) begin
						acc_sum = {accv[63], accv} + {{33{mp[31]}}, mp[31:0]};
						if (REQ.acc_sat && (acc_sum[64] != acc_sum[63])) begin
							acc_sum[63:0] = acc_sum[64] ? 64'h8000000000000000 : 64'h7FFFFFFFFFFFFFFF;
							d.ctrl.ouflag[REQ.acc_sel] = 1'b1;
						end
						{d.acc_hi[REQ.acc_sel], d.acc_lo[REQ.acc_sel]} = acc_sum[63:0];
						d.resp.data = '0;
					end
				end
				dsp_unit_pkg::OP_PRECISION_REDUCE: begin
					// Only halving combinations exist: half from word, byte from half
					if (wo * 2 == wi && wi > dsp_unit_pkg::BYTE_W) begin
						ar = reduce_lanes(REQ.opa, REQ.opb, wi, REQ.round);
						d.resp.data = ar[31:0];
						if (ar[32]) d.ctrl.ouflag[dsp_unit_pkg::OUF_ROUND_BIT] = 1'b1;
					end
				end
				dsp_unit_pkg::OP_ACC_EXTRACT: begin
					fail = q.ctrl.pos < {1'b0, size_eff};
					d.ctrl.extract_fail_flag = fail;
					if (!fail) begin
						lmask = (64'h1 << (size_eff + 6'h01)) - 64'h1;
						d.resp.data = 32'((accv >> (q.ctrl.pos - {1'b0, size_eff})) & lmask);
						if (REQ.decrement) d.ctrl.pos = pos_after_dec;
					end
				end
				dsp_unit_pkg::OP_FIELD_INSERT: begin
					ins_mask = ((64'h1 << q.ctrl.scount) - 64'h1) << q.ctrl.pos;
					d.resp.data = 32'(({32'h0, REQ.opb} & ~ins_mask) | (({32'h0, REQ.opa} << q.ctrl.pos) & ins_mask));
				end
				dsp_unit_pkg::OP_CARRY_ADD: begin
					csum = {1'b0, REQ.opa} + {1'b0, REQ.opb};
					d.resp.data = csum[31:0];
					d.ctrl.carry = csum[32];
				end
				dsp_unit_pkg::OP_ADD_CARRY_IN: begin
					csum = {REQ.opa[31], REQ.opa} + {REQ.opb[31], REQ.opb} + {32'h0, q.ctrl.carry};
					d.resp.data = csum[31:0];
					if (csum[32] != csum[31]) d.ctrl.ouflag[dsp_unit_pkg::OUF_ADD_BIT] = 1'b1;
				end
				dsp_unit_pkg::OP_ACC_SHIFT: begin
					d.acc_hi[REQ.acc_sel] = q.acc_lo[REQ.acc_sel];
					d.acc_lo[REQ.acc_sel] = REQ.opa;
					d.ctrl.pos = q.ctrl.pos + 6'h20;
				end
				dsp_unit_pkg::OP_ACC_WRITE: begin
					if (REQ.left) d.acc_hi[REQ.acc_sel] = REQ.opa;
					else d.acc_lo[REQ.acc_sel] = REQ.opa;
				end
				dsp_unit_pkg::OP_ACC_READ: d.resp.data = REQ.left ? q.acc_hi[REQ.acc_sel] : q.acc_lo[REQ.acc_sel];
				dsp_unit_pkg::OP_CTRL_WRITE: begin
					// The only path that can clear overflow flags
					d.ctrl.pos = REQ.opa[dsp_unit_pkg::POS_LSB +: dsp_unit_pkg::POS_W];
					d.ctrl.scount = REQ.opa[dsp_unit_pkg::SCOUNT_LSB +: dsp_unit_pkg::SCOUNT_W];
					d.ctrl.carry = REQ.opa[dsp_unit_pkg::CARRY_BIT];
					d.ctrl.extract_fail_flag = REQ.opa[dsp_unit_pkg::EXTRACT_FAIL_BIT];
					d.ctrl.ouflag = REQ.opa[dsp_unit_pkg::OUFLAG_LSB +: dsp_unit_pkg::OUFLAG_W];
					d.ctrl.ccond = REQ.opa[dsp_unit_pkg::CCOND_LSB +: dsp_unit_pkg::CCOND_W];
				end
				dsp_unit_pkg::OP_CTRL_READ: d.resp.data = ctrl_word(q.ctrl);
				dsp_unit_pkg::OP_VECTOR_ARRANGE: d.resp.data = arrange_lanes(REQ.opa, wi, BIG_ENDIAN);
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			q <= dsp_unit_pkg::STATE_RESET;
		end else begin
			q <= d;
		end
	end

	assign RESP = q.resp;
	assign CONTROL_STATE = ctrl_word(q.ctrl);

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	logic go;
	assign go = REQ.valid && ENABLE;

	property p_disabled_exc;
		REQ.valid && !ENABLE |=> RESP.valid && RESP.exc && RESP.exc_code == 5'h1A && !RESP.write_gpr;
	endproperty
	a_disabled_exc: assert property (p_disabled_exc) else $error("missing state-disabled exception");

	property p_exc_cause;
		RESP.exc |-> $past(REQ.valid) && !$past(ENABLE);
	endproperty
	a_exc_cause: assert property (p_exc_cause) else $error("exception without disabled extension");

	property p_extract_fail;
		go && REQ.op == dsp_unit_pkg::OP_ACC_EXTRACT && CONTROL_STATE[5:0] < {1'b0, size_eff}
			|=> CONTROL_STATE[14] && $stable(CONTROL_STATE[5:0]);
	endproperty
	a_extract_fail: assert property (p_extract_fail) else $error("extract fail not flagged");

	property p_extract_ok;
		go && REQ.op == dsp_unit_pkg::OP_ACC_EXTRACT && CONTROL_STATE[5:0] >= {1'b0, size_eff} |=> !CONTROL_STATE[14];
	endproperty
	a_extract_ok: assert property (p_extract_ok) else $error("extract fail flag stuck");

	property p_extract_dec;
		go && REQ.op == dsp_unit_pkg::OP_ACC_EXTRACT && REQ.decrement && CONTROL_STATE[5:0] >= {1'b0, size_eff}
			|=> CONTROL_STATE[5:0] == $past(pos_after_dec);
	endproperty
	a_extract_dec: assert property (p_extract_dec) else $error("position not decremented by size+1");

	property p_shift_pos;
		go && REQ.op == dsp_unit_pkg::OP_ACC_SHIFT |=> CONTROL_STATE[5:0] == 6'($past(CONTROL_STATE[5:0]) + 6'h20);
	endproperty
	a_shift_pos: assert property (p_shift_pos) else $error("shift did not add 32 to position");

	property p_ouflag_sticky;
		!(go && REQ.op == dsp_unit_pkg::OP_CTRL_WRITE) |=> ($past(CONTROL_STATE[23:16]) & ~CONTROL_STATE[23:16]) == 8'h00;
	endproperty
	a_ouflag_sticky: assert property (p_ouflag_sticky) else $error("overflow flag cleared");

	property p_carry;
		go && REQ.op == dsp_unit_pkg::OP_CARRY_ADD |=> CONTROL_STATE[13] == $past(add_carry);
	endproperty
	a_carry: assert property (p_carry) else $error("carry bit wrong");

	property p_min_square;
		go && REQ.op == dsp_unit_pkg::OP_FRAC_MUL && REQ.fmt_in == dsp_unit_pkg::FMT_WORD
			&& REQ.opa == 32'h80000000 && REQ.opb == 32'h80000000 |=> RESP.data == 32'h7FFFFFFF && CONTROL_STATE[21];
	endproperty
	a_min_square: assert property (p_min_square) else $error("minus one squared not clamped");

	property p_uns_clamp;
		go && REQ.op == dsp_unit_pkg::OP_ADD && REQ.uns && REQ.sat && REQ.fmt_in == dsp_unit_pkg::FMT_WORD && add_carry
			|=> RESP.data == 32'hFFFFFFFF;
	endproperty
	a_uns_clamp: assert property (p_uns_clamp) else $error("unsigned overflow not clamped");

	c_extract_fail: cover property (go && REQ.op == dsp_unit_pkg::OP_ACC_EXTRACT ##1 CONTROL_STATE[14]);
	c_min_square: cover property (go && REQ.op == dsp_unit_pkg::OP_FRAC_MUL && REQ.opa == 32'h80000000
		&& REQ.opb == 32'h80000000);
	c_disabled: cover property (REQ.valid && !ENABLE ##1 RESP.exc);
	c_acc_clamp: cover property (go && REQ.op == dsp_unit_pkg::OP_MUL_ACC && REQ.acc_sat ##1 CONTROL_STATE[19:16] != 4'h0);

endmodule

// file: core/dsp_unit_pkg.sv
// Shared types and constants for the fixed-point SIMD extension datapath
package dsp_unit_pkg;

	// ********************************
	// Lane formats and operations
	// ********************************
	typedef enum logic [1:0] {
		FMT_WORD = 2'h0,
		FMT_PAIRED_HALF = 2'h1,
		FMT_QUAD_BYTE = 2'h2
	} lane_fmt_t;

	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;
	localparam int NUM_ACC = 4;

	typedef enum logic [3:0] {
		OP_ADD = 4'h0,
		OP_SUB = 4'h1,
		OP_FRAC_MUL = 4'h2,
		OP_FRAC_MUL_WIDE = 4'h3,
		OP_MUL_ACC = 4'h4,
		OP_PRECISION_REDUCE = 4'h5,
		OP_ACC_EXTRACT = 4'h6,
		OP_FIELD_INSERT = 4'h7,
		OP_CARRY_ADD = 4'h8,
		OP_ADD_CARRY_IN = 4'h9,
		OP_ACC_SHIFT = 4'hA,
		OP_ACC_WRITE = 4'hB,
		OP_ACC_READ = 4'hC,
		OP_CTRL_WRITE = 4'hD,
		OP_CTRL_READ = 4'hE,
		OP_VECTOR_ARRANGE = 4'hF
	} op_t;

	// ********************************
	// Control register layout
	// ********************************
	localparam int POS_LSB = 0;
	localparam int POS_W = 6;
	localparam int SCOUNT_LSB = 7;
	localparam int SCOUNT_W = 6;
	localparam int CARRY_BIT = 13;
	localparam int EXTRACT_FAIL_BIT = 14;
	localparam int OUFLAG_LSB = 16;
	localparam int OUFLAG_W = 8;
	localparam int CCOND_LSB = 24;
	localparam int CCOND_W = 4;
	// Overflow flag indices; 0..3 follow the accumulator number
	localparam int OUF_ADD_BIT = 4;
	localparam int OUF_MUL_BIT = 5;
	localparam int OUF_ROUND_BIT = 6;
	localparam logic [4:0] STATE_DISABLED_CODE = 5'h1A;

	typedef struct packed {
		logic [CCOND_W-1:0] ccond;
		logic [OUFLAG_W-1:0] ouflag;
		logic extract_fail_flag;
		logic carry;
		logic [SCOUNT_W-1:0] scount;
		logic [POS_W-1:0] pos;
	} ctrl_fields_t;

	typedef struct packed {
		logic valid;
		op_t op;
		lane_fmt_t fmt_out;
		lane_fmt_t fmt_in;
		logic round;
		logic sat;
		logic acc_sat;
		logic uns;
		logic left;
		logic decrement;
		logic var_size;
		logic [4:0] size;
		logic [1:0] acc_sel;
		logic [31:0] opa;
		logic [31:0] opb;
	} op_request_t;

	typedef struct packed {
		logic valid;
		logic write_gpr;
		logic [31:0] data;
		logic exc;
		logic [4:0] exc_code;
	} op_response_t;

	typedef struct packed {
		logic [NUM_ACC-1:0][31:0] acc_hi;
		logic [NUM_ACC-1:0][31:0] acc_lo;
		ctrl_fields_t ctrl;
		op_response_t resp;
	} unit_state_t;

	localparam unit_state_t STATE_RESET = '0;

endpackage

// file: verification/core_pipe_model.sv
// Core pipeline stand-in that issues one request and captures its response
`timescale 1ns/1ps
module core_pipe_model (
	input wire logic CLOCK,
	output dsp_unit_pkg::op_request_t REQ,
	input wire dsp_unit_pkg::op_response_t RESP,
	output dsp_unit_pkg::op_response_t seen
);
	initial begin
		REQ = '0;
		seen = '0;
	end

	// ********************************
	// Issue
	// ********************************
	// Strobe stands for exactly one rising edge, so each call is one operation
	task automatic issue(input dsp_unit_pkg::op_request_t r);
		dsp_unit_pkg::op_request_t t;
		t = r;
		t.valid = 1'b1;
		@(negedge CLOCK);
		REQ = t;
		// Response pulse stands from the taking edge to the next; take it mid-cycle while settled
		@(negedge CLOCK);
		seen = RESP;
		REQ.valid = 1'b0;
	endtask
endmodule

// file: verification/dsp_simd_fixed_point_unit_tb_top.sv
// Self-checking testbench for the fixed-point SIMD datapath
`timescale 1ns/1ps
module dsp_simd_fixed_point_unit_tb_top;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic ENABLE = 1'b1;
	logic BIG_ENDIAN = 1'b0;
	dsp_unit_pkg::op_request_t REQ;
	dsp_unit_pkg::op_response_t RESP;
	dsp_unit_pkg::op_response_t seen;
	logic [31:0] CONTROL_STATE;
	dsp_unit_pkg::op_request_t r;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;

	always #5 CLOCK = ~CLOCK;

	dsp_unit dut (
		.CLOCK(CLOCK),
		.RST(RST),
		.REQ(REQ),
		.ENABLE(ENABLE),
		.BIG_ENDIAN(BIG_ENDIAN),
		.RESP(RESP),
		.CONTROL_STATE(CONTROL_STATE)
	);

	core_pipe_model pipe (
		.CLOCK(CLOCK),
		.REQ(REQ),
		.RESP(RESP),
		.seen(seen)
	);

	// ********************************
	// Helpers
	// ********************************
	task automatic end_sim;
		$display("Checks done %0d, failures %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic dsp_unit_pkg::op_request_t mk(input dsp_unit_pkg::op_t op,
		input dsp_unit_pkg::lane_fmt_t f, input logic [31:0] a, input logic [31:0] b);
		mk = '0;
		mk.op = op;
		mk.fmt_in = f;
		mk.fmt_out = f;
		mk.opa = a;
		mk.opb = b;
	endfunction

	// Ops that write no register return zero data, so one check serves all
	task automatic run(input string what, input dsp_unit_pkg::op_request_t q, input logic [31:0] exp);
		pipe.issue(q);
		chk({what, " valid"}, 32'h1, {31'h0, seen.valid});
		chk({what, " exc"}, 32'h0, {31'h0, seen.exc});
		chk(what, exp, seen.data);
	endtask

	// Hang guard well above the fewer than a hundred cycles the sequence needs
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_sim();
		end
	end

	// ********************************
	// Sequence
	// ********************************
	initial begin
		repeat (20) @(negedge CLOCK);
		RST = 1'b0;
		chk("control after reset", 32'h0, CONTROL_STATE);
		r = mk(dsp_unit_pkg::OP_CARRY_ADD, dsp_unit_pkg::FMT_WORD, 32'hFFFFFFFF, 32'h1);
		run("carry add", r, 32'h0);
		chk("carry bit", 32'h1, {31'h0, CONTROL_STATE[13]});
		r = mk(dsp_unit_pkg::OP_ADD_CARRY_IN, dsp_unit_pkg::FMT_WORD, 32'h0, 32'h0);
		run("add with carry", r, 32'h1);
		r = mk(dsp_unit_pkg::OP_FRAC_MUL, dsp_unit_pkg::FMT_WORD, 32'h80000000, 32'h80000000);
		run("frac mul min word", r, 32'h7FFFFFFF);
		chk("mul flag set", 32'h1, {31'h0, CONTROL_STATE[21]});
		r = mk(dsp_unit_pkg::OP_FRAC_MUL, dsp_unit_pkg::FMT_PAIRED_HALF, 32'h80004000, 32'h80004000);
		run("frac mul halves", r, 32'h7FFF2000);
		for (int i = 0; i < 2; i++) begin
			r = mk(dsp_unit_pkg::OP_FRAC_MUL, dsp_unit_pkg::FMT_PAIRED_HALF, 32'h00010000, 32'h40000000);
			r.round = i[0];
			run("frac mul round", r, i[0] ? 32'h00010000 : 32'h0);
		end
		r = mk(dsp_unit_pkg::OP_FRAC_MUL_WIDE, dsp_unit_pkg::FMT_PAIRED_HALF, 32'h80000000, 32'h80000000);
		r.left = 1'b1;
		run("wide mul left min", r, 32'h7FFFFFFF);
		r = mk(dsp_unit_pkg::OP_FRAC_MUL_WIDE, dsp_unit_pkg::FMT_PAIRED_HALF, 32'h80004000, 32'h80002000);
		run("wide mul right", r, 32'h10000000);
		r = mk(dsp_unit_pkg::OP_ADD, dsp_unit_pkg::FMT_QUAD_BYTE, 32'h01FF7F00, 32'h01010100);
		r.uns = 1'b1;
		r.sat = 1'b1;
		run("byte add unsigned clamp", r, 32'h02FF8000);
		chk("mul flag sticky", 32'h1, {31'h0, CONTROL_STATE[21]});
		for (int i = 0; i < 2; i++) begin
			r = mk(dsp_unit_pkg::OP_ADD, dsp_unit_pkg::FMT_PAIRED_HALF, 32'h7FFF8000, 32'h0001FFFF);
			r.sat = 1'b1;
			r.uns = i[0];
			run("half add clamp", r, i[0] ? 32'h8000FFFF : 32'h7FFF8000);
		end
		r = mk(dsp_unit_pkg::OP_ADD, dsp_unit_pkg::FMT_WORD, 32'hFFFFFFF0, 32'h00000020);
		r.uns = 1'b1;
		r.sat = 1'b1;
		run("word add unsigned clamp", r, 32'hFFFFFFFF);
		r = mk(dsp_unit_pkg::OP_SUB, dsp_unit_pkg::FMT_WORD, 32'h5, 32'h7);
		run("word sub wrap", r, 32'hFFFFFFFE);
		r = mk(dsp_unit_pkg::OP_CTRL_WRITE, dsp_unit_pkg::FMT_WORD, 32'hFFFFFFFF, 32'h0);
		run("control write ones", r, 32'h0);
		chk("control image", 32'h0FFF7FBF, CONTROL_STATE);
		r.opa = 32'h0;
		run("control write zero", r, 32'h0);
		chk("flags cleared", 32'h0, CONTROL_STATE);
		// Disabled extension: trap with code 26 and leave carry untouched
		ENABLE = 1'b0;
		pipe.issue(mk(dsp_unit_pkg::OP_CARRY_ADD, dsp_unit_pkg::FMT_WORD, 32'hFFFFFFFF, 32'h1));
		chk("disabled exc", 32'h1, {31'h0, seen.exc});
		chk("disabled code", 32'h1A, {27'h0, seen.exc_code});
		chk("disabled no write", 32'h0, {31'h0, seen.write_gpr});
		chk("disabled no state", 32'h0, CONTROL_STATE);
		ENABLE = 1'b1;
		r = mk(dsp_unit_pkg::OP_ACC_WRITE, dsp_unit_pkg::FMT_WORD, 32'h00000FF0, 32'h0);
		r.acc_sel = 2'h2;
		run("acc write", r, 32'h0);
		r = mk(dsp_unit_pkg::OP_CTRL_WRITE, dsp_unit_pkg::FMT_WORD, 32'h0000000B, 32'h0);
		run("pos write", r, 32'h0);
		r = mk(dsp_unit_pkg::OP_ACC_EXTRACT, dsp_unit_pkg::FMT_WORD, 32'h0, 32'h0);
		r.acc_sel = 2'h2;
		r.size = 5'h3;
		r.decrement = 1'b1;
		run("extract decrement", r, 32'hF);
		chk("pos decremented", 32'h7, CONTROL_STATE);
		r.size = 5'h8;
		run("extract short", r, 32'h0);
		chk("extract fail", 32'h4007, CONTROL_STATE);
		r.size = 5'h7;
		r.decrement = 1'b0;
		run("extract exact", r, 32'hF0);
		chk("fail cleared", 32'h7, CONTROL_STATE);
		r = mk(dsp_unit_pkg::OP_ACC_SHIFT, dsp_unit_pkg::FMT_WORD, 32'h0, 32'h0);
		r.acc_sel = 2'h2;
		run("acc shift", r, 32'h0);
		chk("pos plus 32", 32'h27, CONTROL_STATE);
		r.op = dsp_unit_pkg::OP_ACC_READ;
		r.left = 1'b1;
		run("acc high read", r, 32'h00000FF0);
		r = mk(dsp_unit_pkg::OP_CTRL_WRITE, dsp_unit_pkg::FMT_WORD, 32'h00000404, 32'h0);
		run("insert setup", r, 32'h0);
		r = mk(dsp_unit_pkg::OP_FIELD_INSERT, dsp_unit_pkg::FMT_WORD, 32'h000000AB, 32'hFFFFFFFF);
		run("field insert", r, 32'hFFFFFABF);
		for (int i = 0; i < 2; i++) begin
			BIG_ENDIAN = i[0];
			r = mk(dsp_unit_pkg::OP_VECTOR_ARRANGE, dsp_unit_pkg::FMT_QUAD_BYTE, 32'h11223344, 32'h0);
			run("lane order", r, i[0] ? 32'h44332211 : 32'h11223344);
		end
		r = mk(dsp_unit_pkg::OP_PRECISION_REDUCE, dsp_unit_pkg::FMT_WORD, 32'h12345678, 32'h9ABCDEF0);
		r.fmt_out = dsp_unit_pkg::FMT_PAIRED_HALF;
		run("reduce to halves", r, 32'h12349ABC);
		// Accumulator one sits at the positive maximum, so a positive product must clamp it
		r = mk(dsp_unit_pkg::OP_ACC_WRITE, dsp_unit_pkg::FMT_WORD, 32'h7FFFFFFF, 32'h0);
		r.acc_sel = 2'h1;
		r.left = 1'b1;
		run("acc1 high write", r, 32'h0);
		r.opa = 32'hFFFFFFFF;
		r.left = 1'b0;
		run("acc1 low write", r, 32'h0);
		r.op = dsp_unit_pkg::OP_MUL_ACC;
		r.opa = 32'h00004000;
		r.opb = 32'h00004000;
		r.acc_sat = 1'b1;
		run("mac clamp", r, 32'h0);
		chk("acc clamp flag", 32'h1, {31'h0, CONTROL_STATE[17]});
		r.op = dsp_unit_pkg::OP_ACC_READ;
		run("acc1 low clamped", r, 32'hFFFFFFFF);
		r.left = 1'b1;
		run("acc1 high clamped", r, 32'h7FFFFFFF);
		end_sim();
	end
endmodule
